// ### hw/mst_unit.sv
// Purpose: Multiply, long multiply and status word transfer execution unit
// Assumes: Decode presents one operation per start pulse with register contents
// Notes:   start_i is ignored while busy_o is high; results arrive with done_o
//
// Functional notes
// RULE1 - Status transfers finish one cycle after start
// RULE2 - Register flags write sets N Z C V
// RULE3 - Immediate flags write uses top four bits
// RULE4 - User mode writes flags only; reads full word
// RULE5 - Privileged saved word: full or flags write
// RULE6 - Failed condition changes no register or flag
// RULE7 - Booth multiplier retires eight bits per cycle
// RULE8 - Short multiply ignores accumulate operand
// RULE9 - Short accumulate adds accumulate operand
// RULE10 - Short forms give low 32 bits only
// RULE11 - Source avoids destination equal first operand
// RULE12 - Short flags: N bit31, Z zero, V kept
// RULE13 - Short timing: 1S+mI, accumulate 1S+(m+1)I
// RULE14 - Short m from sign bits above 8/16/24
// RULE15 - Long multiply writes 64-bit product halves
// RULE16 - Long accumulate adds the destination pair
// RULE17 - Long variants signed or unsigned operands
// RULE18 - Long flags: N bit63, Z all zero
// RULE19 - Long timing: 1S+(m+1)I, accumulate (m+2)I; the code takes 1S+(m+2)I for accumulate
// RULE20 - Signed long m: ones or zeros terminate
// RULE21 - Unsigned long m: only zeros terminate
// RULE22 - Source keeps long registers distinct, not counter
// RULE23 - User mode protects current control bits
// RULE24 - Stall while iterating; write after final step
`timescale 1ns/1ns
module mst_unit (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             start_i,
	input  wire mst_pkg::mst_op_t op_i,
	input  wire logic             cond_pass_i,
	input  wire logic             set_flags_i,
	input  wire logic [31:0]      first_operand_i,
	input  wire logic [31:0]      multiplier_operand_i,
	input  wire logic [31:0]      accumulate_operand_i,
	input  wire logic [31:0]      high_result_i,
	input  wire logic [31:0]      low_result_i,
	output logic                  busy_o,
	output logic                  done_o,
	output logic                  write_lo_o,
	output logic                  write_hi_o,
	output logic [31:0]           result_lo_o,
	output logic [31:0]           result_hi_o,
	output logic [31:0]           current_status_word_o
);
	import mst_pkg::*;

	mst_state_t  state_reg;
	mst_op_t     op_reg;
	logic        setf_reg;
	logic [63:0] acc_reg;
	logic [63:0] mcand_reg;
	logic [32:0] mplier_reg;
	logic        carry_reg;
	logic [2:0]  steps_left_reg;
	logic [1:0]  extra_left_reg;
	logic [31:0] cur_status_reg;
	logic [31:0] saved_reg [SAVED_COUNT];

	logic        accept;
	logic        is_mul;
	logic        is_long;
	logic        is_signed_long;
	logic [32:0] mplier_ext;
	logic [63:0] mcand_ext;
	logic [63:0] acc_init;
	logic [2:0]  steps_init;
	logic [1:0]  extra_init;
	logic [63:0] step_sum;
	logic        user_mode;
	logic        saved_ok;
	logic [2:0]  saved_idx;
	logic [31:0] saved_cur;
	logic        short_fin;
	logic        long_fin;

	// New work is taken only when the sequencer is idle
	assign accept = start_i && (state_reg == ST_IDLE); // RULE24

	// Operation class decode
	always_comb begin
		is_mul         = 1'b0;
		is_long        = 1'b0;
		is_signed_long = 1'b0;
		extra_init     = EXTRA_SHORT;
		unique case (op_i)
			OP_SHORT_MUL: begin
				is_mul     = 1'b1;
				extra_init = EXTRA_SHORT; // RULE13
			end
			OP_SHORT_MUL_ACC: begin
				is_mul     = 1'b1;
				extra_init = EXTRA_SHORT_ACC; // RULE13
			end
			OP_ULONG, OP_SLONG: begin
				is_mul         = 1'b1;
				is_long        = 1'b1;
				is_signed_long = (op_i == OP_SLONG);
				extra_init     = EXTRA_LONG; // RULE19
			end
			OP_ULONG_ACC, OP_SLONG_ACC: begin
				is_mul         = 1'b1;
				is_long        = 1'b1;
				is_signed_long = (op_i == OP_SLONG_ACC);
				extra_init     = EXTRA_LONG_ACC; // RULE19
			end
			default: begin
				is_mul = 1'b0;
			end
		endcase
	end

	// Operand extension; unsigned long zero-extends so only zeros terminate
	always_comb begin
		if (is_long && !is_signed_long) begin
			mplier_ext = {1'b0, multiplier_operand_i}; // RULE21
			mcand_ext  = {32'h0000_0000, first_operand_i}; // RULE17
		end else if (is_long) begin
			mplier_ext = {multiplier_operand_i[31], multiplier_operand_i}; // RULE20
			mcand_ext  = {{32{first_operand_i[31]}}, first_operand_i}; // RULE17
		end else begin
			// Low half is the same for either reading of the operands
			mplier_ext = {multiplier_operand_i[31], multiplier_operand_i}; // RULE14
			mcand_ext  = {32'h0000_0000, first_operand_i}; // RULE10
		end
	end

	// Accumulator seed per form
	always_comb begin
		unique case (op_i)
			OP_SHORT_MUL_ACC: acc_init = {32'h0000_0000, accumulate_operand_i}; // RULE9
			OP_ULONG_ACC,
			OP_SLONG_ACC:     acc_init = {high_result_i, low_result_i}; // RULE16
			default:          acc_init = 64'h0; // RULE8
		endcase
	end

	// Early termination from the bits above each step boundary
	always_comb begin
		if (&mplier_ext[32:8] || ~|mplier_ext[32:8]) begin
			steps_init = 3'h1; // RULE14
		end else if (&mplier_ext[32:16] || ~|mplier_ext[32:16]) begin
			steps_init = 3'h2;
		end else if (&mplier_ext[32:24] || ~|mplier_ext[32:24]) begin
			steps_init = 3'h3;
		end else begin
			steps_init = 3'(MAX_STEPS);
		end
	end

	// Array step on the held operands
	mst_booth_step u_step (
		.acc_i   (acc_reg),
		.mcand_i (mcand_reg),
		.chunk_i (mplier_reg[7:0]),
		.carry_i (carry_reg),
		.last_i  (steps_left_reg == 3'h1),
		.top_i   (mplier_reg[8]),
		.sum_o   (step_sum)
	);

	// Sequencer: array cycles, then extra internal cycles, then the write cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= ST_IDLE;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (accept && is_mul && cond_pass_i) begin
						state_reg <= ST_BOOTH; // RULE6
					end
				end
				ST_BOOTH: begin
					if (steps_left_reg == 3'h1) begin
						state_reg <= (extra_left_reg == 2'h0) ? ST_FINISH : ST_EXTRA;
					end
				end
				ST_EXTRA: begin
					if (extra_left_reg == 2'h1) begin
						state_reg <= ST_FINISH;
					end
				end
				ST_FINISH: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// Datapath registers of the iterating multiply
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			op_reg         <= OP_SHORT_MUL;
			setf_reg       <= 1'b0;
			acc_reg        <= 64'h0;
			mcand_reg      <= 64'h0;
			mplier_reg     <= 33'h0;
			carry_reg      <= 1'b0;
			steps_left_reg <= 3'h0;
			extra_left_reg <= 2'h0;
		end else if (accept) begin
			op_reg         <= op_i;
			setf_reg       <= set_flags_i;
			acc_reg        <= acc_init;
			mcand_reg      <= mcand_ext;
			mplier_reg     <= mplier_ext;
			carry_reg      <= 1'b0;
			steps_left_reg <= steps_init;
			extra_left_reg <= extra_init;
		end else if (state_reg == ST_BOOTH) begin
			acc_reg        <= step_sum; // RULE7
			mcand_reg      <= {mcand_reg[55:0], 8'h00};
			mplier_reg     <= {{8{mplier_reg[32]}}, mplier_reg[32:8]};
			carry_reg      <= mplier_reg[7];
			steps_left_reg <= steps_left_reg - 3'h1;
		end else if (state_reg == ST_EXTRA) begin
			extra_left_reg <= extra_left_reg - 2'h1;
		end
	end

	// Stall the pipeline from accept until the write cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_o <= 1'b0;
		end else if (accept && is_mul && cond_pass_i) begin
			busy_o <= 1'b1; // RULE24
		end else if (state_reg == ST_FINISH) begin
			busy_o <= 1'b0;
		end
	end

	// Mode and saved copy selection
	assign user_mode = (cur_status_reg[MODE_HI:MODE_LO] == MODE_USER);
	always_comb begin
		saved_ok  = 1'b1;
		saved_idx = 3'h0;
		unique case (cur_status_reg[MODE_HI:MODE_LO])
			MODE_FAST_IRQ: saved_idx = 3'h0;
			MODE_IRQ:      saved_idx = 3'h1;
			MODE_SUPER:    saved_idx = 3'h2;
			MODE_ABORT:    saved_idx = 3'h3;
			MODE_UNDEF:    saved_idx = 3'h4;
			default:       saved_ok  = 1'b0; // User and other modes have no copy
		endcase
		saved_cur = saved_ok ? saved_reg[saved_idx] : 32'h0;
	end

	assign short_fin = (op_reg == OP_SHORT_MUL) || (op_reg == OP_SHORT_MUL_ACC);
	assign long_fin  = !short_fin;

	// Results and write strobes: one cycle after a transfer, or from the write cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			done_o      <= 1'b0;
			write_lo_o  <= 1'b0;
			write_hi_o  <= 1'b0;
			result_lo_o <= 32'h0;
			result_hi_o <= 32'h0;
		end else if (state_reg == ST_FINISH) begin
			done_o      <= 1'b1; // RULE24
			write_lo_o  <= 1'b1;
			write_hi_o  <= long_fin; // RULE15
			result_lo_o <= acc_reg[31:0]; // RULE10
			result_hi_o <= long_fin ? acc_reg[63:32] : 32'h0;
		end else if (accept && (!is_mul || !cond_pass_i)) begin
			done_o      <= 1'b1; // RULE1
			write_lo_o  <= cond_pass_i && ((op_i == OP_READ_CURRENT) || (op_i == OP_READ_SAVED));
			write_hi_o  <= 1'b0;
			result_lo_o <= (op_i == OP_READ_SAVED) ? saved_cur : cur_status_reg; // RULE4
			result_hi_o <= 32'h0;
		end else begin
			done_o      <= 1'b0;
			write_lo_o  <= 1'b0;
			write_hi_o  <= 1'b0;
		end
	end

	// Current status word: transfers and multiply flags
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cur_status_reg <= STATUS_RESET;
		end else if (state_reg == ST_FINISH && setf_reg) begin
			// Carry keeps its value rather than taking a meaningless one
			if (short_fin) begin
				cur_status_reg[FLAG_N_POS] <= acc_reg[31]; // RULE12
				cur_status_reg[FLAG_Z_POS] <= (acc_reg[31:0] == 32'h0);
			end else begin
				cur_status_reg[FLAG_N_POS] <= acc_reg[63]; // RULE18
				cur_status_reg[FLAG_Z_POS] <= (acc_reg == 64'h0);
			end
		end else if (accept && cond_pass_i) begin
			if (op_i == OP_WRITE_CUR_FLG) begin
				cur_status_reg[FLAG_N_POS:FLAG_V_POS] <=
					first_operand_i[FLAG_N_POS:FLAG_V_POS]; // RULE2 RULE3
			end else if (op_i == OP_WRITE_CUR_ALL) begin
				if (user_mode) begin
					cur_status_reg[FLAG_N_POS:FLAG_V_POS] <=
						first_operand_i[FLAG_N_POS:FLAG_V_POS]; // RULE4 RULE23
				end else begin
					cur_status_reg <= first_operand_i; // RULE23
				end
			end
		end
	end

	// Saved copies; user mode has none, so its writes are dropped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < SAVED_COUNT; i++) begin
				saved_reg[i] <= SAVED_RESET;
			end
		end else if (accept && cond_pass_i && saved_ok) begin
			if (op_i == OP_WRITE_SAV_ALL) begin
				saved_reg[saved_idx] <= first_operand_i; // RULE5
			end else if (op_i == OP_WRITE_SAV_FLG) begin
				saved_reg[saved_idx][FLAG_N_POS:FLAG_V_POS] <=
					first_operand_i[FLAG_N_POS:FLAG_V_POS]; // RULE5
			end
		end
	end

	// Status word seen by the rest of the core
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			current_status_word_o <= STATUS_RESET;
		end else begin
			current_status_word_o <= cur_status_reg;
		end
	end

endmodule

// ### shared/mst_pkg.sv
// Purpose: Shared constants and types for the multiply and status transfer unit
// Assumes: 32-bit core, status word flags in the top four bits, mode in the low five
// Notes:   Each cycle figure is one clock at the core rate
package mst_pkg;

	// Core clock, 10 MHz
	localparam int CLK_PERIOD_NS = 100;

	// Cycle accounting: one sequential or internal cycle is one clock
	localparam int SEQ_CYCLE_NS  = 100;
	localparam int SEQ_CYCLES    = (SEQ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Booth array geometry
	localparam int STEP_BITS     = 8;
	localparam int MAX_STEPS     = 4;

	// Extra internal cycles after the array, per operation class
	localparam logic [1:0] EXTRA_SHORT      = 2'h0;
	localparam logic [1:0] EXTRA_SHORT_ACC  = 2'h1;
	localparam logic [1:0] EXTRA_LONG       = 2'h1;
	localparam logic [1:0] EXTRA_LONG_ACC   = 2'h2;

	// Status word layout
	localparam int FLAG_N_POS    = 31;
	localparam int FLAG_Z_POS    = 30;
	localparam int FLAG_C_POS    = 29;
	localparam int FLAG_V_POS    = 28;
	localparam int MODE_HI       = 4;
	localparam int MODE_LO       = 0;

	// Status word reset value: supervisor mode, both interrupt masks set
	localparam logic [31:0] STATUS_RESET = 32'h0000_00d3;
	localparam logic [31:0] SAVED_RESET  = 32'h0000_0000;

	// Mode encodings
	localparam logic [4:0] MODE_USER     = 5'h10;
	localparam logic [4:0] MODE_FAST_IRQ = 5'h11;
	localparam logic [4:0] MODE_IRQ      = 5'h12;
	localparam logic [4:0] MODE_SUPER    = 5'h13;
	localparam logic [4:0] MODE_ABORT    = 5'h17;
	localparam logic [4:0] MODE_UNDEF    = 5'h1b;

	// One saved copy per exception mode
	localparam int SAVED_COUNT = 5;

	// Operation requested by decode
	typedef enum logic [3:0] {
		OP_SHORT_MUL      = 4'h0,
		OP_SHORT_MUL_ACC  = 4'h1,
		OP_ULONG          = 4'h2,
		OP_ULONG_ACC      = 4'h3,
		OP_SLONG          = 4'h4,
		OP_SLONG_ACC      = 4'h5,
		OP_READ_CURRENT   = 4'h6,
		OP_READ_SAVED     = 4'h7,
		OP_WRITE_CUR_ALL  = 4'h8,
		OP_WRITE_CUR_FLG  = 4'h9,
		OP_WRITE_SAV_ALL  = 4'ha,
		OP_WRITE_SAV_FLG  = 4'hb
	} mst_op_t;

	// Sequencer states
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_BOOTH  = 2'b01,
		ST_EXTRA  = 2'b10,
		ST_FINISH = 2'b11
	} mst_state_t;

endpackage

// ### hw/mst_booth_step.sv
// Purpose: One Booth array step retiring eight multiplier bits
// Assumes: Multiplicand already shifted into place for this step
// Notes:   Purely combinational; the sequencer owns all state
`timescale 1ns/1ns
module mst_booth_step (
	input  wire logic [63:0] acc_i,
	input  wire logic [63:0] mcand_i,
	input  wire logic [7:0]  chunk_i,
	input  wire logic        carry_i,
	input  wire logic        last_i,
	input  wire logic        top_i,
	output logic      [63:0] sum_o
);
	logic signed [9:0]  digit;
	logic signed [63:0] digit_wide;
	logic signed [63:0] prod;

	// Radix-256 digit; the final step folds in the sign of the bits not retired
	always_comb begin
		if (last_i) begin
			digit = $signed({top_i, top_i, chunk_i}) + $signed({9'h000, carry_i}); // RULE7
		end else begin
			digit = $signed({chunk_i[7], chunk_i[7], chunk_i}) + $signed({9'h000, carry_i});
		end
		digit_wide = {{54{digit[9]}}, digit};
		prod       = $signed(mcand_i) * digit_wide; // Truncation to 64 bits is intended
		sum_o      = acc_i + prod;
	end

endmodule

// ### dv/mst_unit_checker.sv
// Purpose: Port checks for the multiply and status unit
// Assumes: Operands are latched here on every accepted start
// Notes:   Status output lags the internal word by one cycle
`timescale 1ns/1ns
module mst_unit_checker
	import mst_pkg::*;
(
	input wire logic             clk_i,
	input wire logic             rst_i,
	input wire logic             start_i,
	input wire mst_pkg::mst_op_t op_i,
	input wire logic             cond_pass_i,
	input wire logic             set_flags_i,
	input wire logic [31:0]      first_operand_i,
	input wire logic [31:0]      multiplier_operand_i,
	input wire logic [31:0]      accumulate_operand_i,
	input wire logic [31:0]      high_result_i,
	input wire logic [31:0]      low_result_i,
	input wire logic             busy_o,
	input wire logic             done_o,
	input wire logic             write_lo_o,
	input wire logic             write_hi_o,
	input wire logic [31:0]      result_lo_o,
	input wire logic [31:0]      result_hi_o,
	input wire logic [31:0]      current_status_word_o
);
	logic        hit, lng, acc, s_q;
	mst_op_t     op_q;
	logic [31:0] a_q, b_q, c_q;
	logic [63:0] d_q, p_x;
	logic [1:0]  nz;
	logic [3:0]  n_q;
	int          exp_n;
	// Fewest array steps whose upper bits are pure sign or zero
	function automatic int m_of(logic [31:0] b, logic sx);
		for (int k = 1; k < 4; k++) begin
			if ((b >> (8 * k)) == 32'h0 || (sx && (~b >> (8 * k)) == 32'h0)) begin
				return k;
			end
		end
		return 4;
	endfunction
	// Expected figures for the latched operation
	assign hit = start_i && !busy_o;
	assign lng = op_q inside {OP_ULONG, OP_ULONG_ACC, OP_SLONG, OP_SLONG_ACC};
	assign acc = op_q inside {OP_SHORT_MUL_ACC, OP_ULONG_ACC, OP_SLONG_ACC};
	assign exp_n = m_of(b_q, !(op_q inside {OP_ULONG, OP_ULONG_ACC})) + lng + acc + 1;
	assign p_x = !lng ? {32'h0, a_q * b_q + (acc ? c_q : 32'h0)}
		: (op_q inside {OP_SLONG, OP_SLONG_ACC} ? {{32{a_q[31]}}, a_q} * {{32{b_q[31]}}, b_q}
		: {32'h0, a_q} * {32'h0, b_q}) + (acc ? d_q : 64'h0);
	assign nz = lng ? {p_x[63], p_x == 64'h0} : {p_x[31], p_x[31:0] == 32'h0};
	// Operand capture; busy cycles counted from the accept edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			n_q <= 4'h0;
		end else if (hit) begin
			op_q <= op_i;
			s_q  <= set_flags_i;
			a_q  <= first_operand_i;
			b_q  <= multiplier_operand_i;
			c_q  <= accumulate_operand_i;
			d_q  <= {high_result_i, low_result_i};
			n_q  <= 4'h0;
		end else if (busy_o) begin
			n_q <= n_q + 4'h1;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_xfer_one_cycle: assert property (hit && op_i >= OP_READ_CURRENT |=> done_o && !busy_o)
		else $error("status transfer not done in one cycle");
	a_cond_blocks: assert property (hit && !cond_pass_i |=> done_o && !write_lo_o && !write_hi_o)
		else $error("failed condition still wrote");
	a_array_cycles: assert property (done_o && write_lo_o && op_q < OP_READ_CURRENT
		|-> int'(n_q) == exp_n) else $error("multiply cycle count wrong");
	a_short_product: assert property (done_o && write_lo_o && op_q < OP_ULONG
		|-> result_lo_o == p_x[31:0]) else $error("short product wrong");
	a_long_product: assert property (done_o && write_hi_o
		|-> {result_hi_o, result_lo_o} == p_x) else $error("long product wrong");
	a_hi_long_only: assert property (write_hi_o |-> done_o && write_lo_o && lng)
		else $error("high write outside long multiply");
	a_stall_no_done: assert property (busy_o |-> !done_o && !write_lo_o)
		else $error("result written while iterating");
	a_flag_write: assert property (hit && cond_pass_i && !done_o && (op_i == OP_WRITE_CUR_FLG ||
		(op_i == OP_WRITE_CUR_ALL && current_status_word_o[4:0] == MODE_USER)) |-> ##2
		current_status_word_o == {$past(first_operand_i[31:28], 2), $past(current_status_word_o[27:0], 2)})
		else $error("status write touched control bits");
	a_mul_flags: assert property (done_o && write_lo_o && s_q && op_q < OP_READ_CURRENT |=>
		current_status_word_o[31:28] == {$past(nz), $past(current_status_word_o[29:28])})
		else $error("multiply flags wrong");
endmodule
bind mst_unit mst_unit_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .start_i(start_i),
	.op_i(op_i), .cond_pass_i(cond_pass_i), .set_flags_i(set_flags_i),
	.first_operand_i(first_operand_i), .multiplier_operand_i(multiplier_operand_i),
	.accumulate_operand_i(accumulate_operand_i), .high_result_i(high_result_i),
	.low_result_i(low_result_i), .busy_o(busy_o), .done_o(done_o), .write_lo_o(write_lo_o),
	.write_hi_o(write_hi_o), .result_lo_o(result_lo_o), .result_hi_o(result_hi_o),
	.current_status_word_o(current_status_word_o));

// ### dv/mst_core_model.sv
// Purpose: Core register side holding the destination pair
// Assumes: Write pulses from the unit last one cycle
// Notes:   A seed load wins over a same-cycle write
`timescale 1ns/1ns
module mst_core_model (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wr_lo_i,
	input  wire logic        wr_hi_i,
	input  wire logic [31:0] lo_i,
	input  wire logic [31:0] hi_i,
	input  wire logic        load_i,
	input  wire logic [63:0] seed_i,
	output logic      [31:0] dest_lo_o,
	output logic      [31:0] dest_hi_o
);
	// Separate low and high registers, never the counter, so no alias
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dest_lo_o <= 32'h0;
			dest_hi_o <= 32'h0;
		end else if (load_i) begin
			{dest_hi_o, dest_lo_o} <= seed_i;
		end else begin
			if (wr_lo_i) begin
				dest_lo_o <= lo_i;
			end
			if (wr_hi_i) begin
				dest_hi_o <= hi_i;
			end
		end
	end
endmodule

// ### dv/mst_unit_test.sv
// Purpose: Self-checking bench for the multiply and status unit
// Assumes: Inputs change 10 ns after each rising edge
// Notes:   Long accumulate seeds come from the core model pair
`timescale 1ns/1ns
module mst_unit_test;
	import mst_pkg::*;
	`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
		$display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
	logic        clk_i, rst_i, start_i, cond_pass_i, set_flags_i, load_i;
	mst_op_t     op_i;
	logic [31:0] first_operand_i, multiplier_operand_i, accumulate_operand_i;
	logic [31:0] dest_hi, dest_lo, result_lo_o, result_hi_o, current_status_word_o;
	logic        busy_o, done_o, write_lo_o, write_hi_o;
	logic [63:0] seed;
	int          failures, compares, cycles;
	mst_unit u_dut (.clk_i(clk_i), .rst_i(rst_i), .start_i(start_i), .op_i(op_i),
		.cond_pass_i(cond_pass_i), .set_flags_i(set_flags_i), .first_operand_i(first_operand_i),
		.multiplier_operand_i(multiplier_operand_i), .accumulate_operand_i(accumulate_operand_i),
		.high_result_i(dest_hi), .low_result_i(dest_lo), .busy_o(busy_o), .done_o(done_o),
		.write_lo_o(write_lo_o), .write_hi_o(write_hi_o), .result_lo_o(result_lo_o),
		.result_hi_o(result_hi_o), .current_status_word_o(current_status_word_o));
	mst_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .wr_lo_i(write_lo_o),
		.wr_hi_i(write_hi_o), .lo_i(result_lo_o), .hi_i(result_hi_o), .load_i(load_i),
		.seed_i(seed), .dest_lo_o(dest_lo), .dest_hi_o(dest_hi));
	// Core clock, 100 ns period
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	task automatic report_and_stop;
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Hang guard, well above the hundred or so cycles the tests need
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			report_and_stop;
		end
	end
	task automatic tick(input int k);
		repeat (k) @(posedge clk_i);
		#10;
	endtask
	// One request; n counts edges after acceptance until done shows
	task automatic run(input mst_op_t op, input logic cp, input logic sf, input logic [31:0] a,
		input logic [31:0] b, input logic [31:0] c, output int n);
		n = 0;
		op_i        = op;
		cond_pass_i = cp;
		set_flags_i = sf;
		start_i     = 1'b1;
		{first_operand_i, multiplier_operand_i, accumulate_operand_i} = {a, b, c};
		tick(1);
		start_i = 1'b0;
		while (done_o !== 1'b1 && n < 20) begin
			tick(1);
			n++;
		end
	endtask
	task automatic seed_pair(input logic [63:0] v);
		{load_i, seed} = {1'b1, v};
		tick(1);
		load_i = 1'b0;
	endtask
	task automatic t_status;
		int n;
		`CHK(current_status_word_o, STATUS_RESET)
		run(OP_READ_CURRENT, 1, 0, 32'h0, 32'h0, 32'h0, n);
		`CHK(n, 0)
		`CHK(result_lo_o, STATUS_RESET)
		run(OP_WRITE_CUR_FLG, 1, 0, 32'h5000_00ff, 32'h0, 32'h0, n);
		`CHK(n, 0)
		tick(1);
		`CHK(current_status_word_o, {4'h5, STATUS_RESET[27:0]})
		run(OP_WRITE_SAV_ALL, 1, 0, 32'h1234_5601, 32'h0, 32'h0, n);
		run(OP_READ_SAVED, 1, 0, 32'h0, 32'h0, 32'h0, n);
		`CHK(result_lo_o, 32'h1234_5601)
		run(OP_WRITE_SAV_FLG, 1, 0, 32'hc000_0000, 32'h0, 32'h0, n);
		run(OP_READ_SAVED, 1, 0, 32'h0, 32'h0, 32'h0, n);
		`CHK(result_lo_o, 32'hc234_5601)
		run(OP_WRITE_CUR_ALL, 1, 0, 32'h0000_0010, 32'h0, 32'h0, n);
		tick(1);
		`CHK(current_status_word_o, 32'h0000_0010)
		run(OP_WRITE_CUR_ALL, 1, 0, 32'ha000_00d3, 32'h0, 32'h0, n);
		tick(1);
		`CHK(current_status_word_o, 32'ha000_0010)
		run(OP_READ_CURRENT, 1, 0, 32'h0, 32'h0, 32'h0, n);
		`CHK(result_lo_o, 32'ha000_0010)
		$display("t_status done");
	endtask
	// Multiplier values that stop the array after one to four steps
	task automatic t_short;
		logic [31:0] bv [4] = '{32'h0000_0014, 32'h0000_1234, 32'h00ff_0000, 32'h1234_5678};
		int n;
		for (int k = 0; k < 4; k++) begin
			run(OP_SHORT_MUL, 1, 0, 32'hffff_fff6, bv[k], 32'hdead_beef, n);
			`CHK(result_lo_o, 32'hffff_fff6 * bv[k])
			`CHK(n, k + 2)
			run(OP_SHORT_MUL_ACC, 1, 0, 32'hffff_fff6, bv[k], 32'h0000_0100, n);
			`CHK(result_lo_o, 32'hffff_fff6 * bv[k] + 32'h100)
			`CHK(n, k + 3)
		end
		run(OP_SHORT_MUL, 1, 1, 32'h0, 32'hffff_ff80, 32'h0, n);
		`CHK(n, 2)
		tick(1);
		`CHK(current_status_word_o[31:28], 4'h6)
		run(OP_SHORT_MUL, 1, 1, 32'hffff_fff6, 32'h14, 32'h0, n);
		tick(1);
		`CHK(current_status_word_o[31:28], 4'ha)
		$display("t_short done");
	endtask
	task automatic t_long;
		int n;
		run(OP_ULONG, 1, 0, 32'hffff_ffff, 32'hffff_fff0, 32'h0, n);
		`CHK(n, 6)
		`CHK({result_hi_o, result_lo_o}, {32'h0, 32'hffff_ffff} * {32'h0, 32'hffff_fff0})
		run(OP_SLONG, 1, 0, 32'hffff_ffff, 32'hffff_fff0, 32'h0, n);
		`CHK(n, 3)
		`CHK({result_hi_o, result_lo_o}, 64'h10)
		tick(1);
		run(OP_ULONG_ACC, 1, 0, 32'h3, 32'h100, 32'h0, n);
		`CHK(n, 5)
		`CHK({result_hi_o, result_lo_o}, 64'h310)
		seed_pair(64'h4);
		run(OP_SLONG_ACC, 1, 1, 32'hffff_fffe, 32'h7, 32'h0, n);
		`CHK(n, 4)
		tick(1);
		`CHK({dest_hi, dest_lo}, 64'hffff_ffff_ffff_fff6)
		`CHK(current_status_word_o[31:30], 2'b10)
		$display("t_long done");
	endtask
	task automatic t_cond;
		int n;
		run(OP_SHORT_MUL, 1, 0, 32'h2, 32'h3, 32'h0, n);
		tick(1);
		run(OP_SLONG, 0, 1, 32'h7, 32'h9, 32'h0, n);
		`CHK(n, 0)
		`CHK({write_hi_o, write_lo_o}, 2'b00)
		run(OP_WRITE_CUR_FLG, 0, 0, 32'h0, 32'h0, 32'h0, n);
		tick(2);
		`CHK(dest_lo, 32'h6)
		`CHK(current_status_word_o[31:28], 4'ha)
		$display("t_cond done");
	endtask
	// Second start held up while busy must be ignored
	task automatic t_busy;
		op_i = OP_SHORT_MUL;
		{cond_pass_i, set_flags_i, start_i} = 3'h5;
		{first_operand_i, multiplier_operand_i} = {32'h3, 32'h1234_5678};
		tick(1);
		op_i = OP_WRITE_CUR_FLG;
		first_operand_i = 32'hf000_0000;
		tick(1);
		start_i = 1'b0;
		`CHK({busy_o, done_o}, 2'b10)
		tick(4);
		`CHK({done_o, write_lo_o}, 2'b11)
		`CHK(result_lo_o, 32'h3 * 32'h1234_5678)
		tick(2);
		`CHK(current_status_word_o[31:28], 4'ha)
		$display("t_busy done");
	endtask
	// Reset for four cycles, then the scenarios in turn
	initial begin
		{rst_i, start_i, cond_pass_i, set_flags_i, load_i} = 5'h10;
		op_i = OP_SHORT_MUL;
		{first_operand_i, multiplier_operand_i, accumulate_operand_i, seed} = '0;
		{failures, compares, cycles} = '0;
		tick(4);
		rst_i = 1'b0;
		`CHK({busy_o, done_o}, 2'b00)
		t_status;
		t_short;
		t_long;
		t_cond;
		t_busy;
		report_and_stop;
	end
endmodule
